//--- rtl/mcu_memory_map_decoder.sv
// memory map decoder: flash partition, vectors, internal and auxiliary ram, stack
`timescale 1ns/10ps
// Function
// - fetch starts at address 0000h after reset
// - interrupt vectors at 0003h plus eight each
// - flash blocks organised in 128-byte pages
// - size field splits 18K between boot, application
// - config byte resets to all ones
// - boot mode maps pc zero to boot start
// - direct high goes special, indirect high ram
// - only x0h/x8h special registers bit-accessible
// - four banks of eight working registers
// - bytes 20h-2fh hold 128 bit addresses
// - stack pointer resets to 07h, loadable anywhere
// - push increments first, pop decrements after
// - calls push return address, low byte first
// - 256-byte auxiliary ram via external moves
// - stack always addresses internal ram
// - 256 bytes internal ram, separate space
// - application programs boot, boot programs rest
// - running block's flash serves fetch and code reads
module mcu_memory_map_decoder import mmap_pkg::*; #(
  parameter int ADDR_W = 8 // register bus address width
) (
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // program memory side
  input wire logic boot_mode,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_pc,
  input wire logic fetch_code_read,
  output logic [14:0] flash_addr_r,
  output logic [PAGE_BITS:0] flash_page_r,
  output logic flash_in_boot_r,
  output logic flash_fault_r,
  output logic flash_code_read_r,
  input wire logic irq_valid,
  input wire logic [2:0] irq_num,
  output logic [15:0] vector_addr_r,
  input wire prog_req_t prog_req,
  output logic prog_allow_r,
  output logic prog_deny_r,
  // internal data side
  input wire dm_req_t dm_req,
  output logic [7:0] dm_rdata_r,
  output logic dm_rvalid_r,
  output logic sfr_sel_r,
  output logic [7:0] sfr_addr_r,
  output logic sfr_bit_ok_r,
  input wire logic bank_select_high,
  input wire logic bank_select_low,
  input wire logic reg_valid,
  input wire logic reg_write,
  input wire logic [2:0] reg_idx,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_r,
  // stack side
  input wire logic sp_load,
  input wire logic [7:0] sp_load_val,
  input wire logic push_valid,
  input wire logic [7:0] push_data,
  input wire logic pop_valid,
  output logic [7:0] pop_data_r,
  input wire logic call_valid,
  input wire logic [15:0] call_addr,
  output logic stack_busy,
  output logic [7:0] stack_pointer,
  // auxiliary ram side
  input wire xm_req_t xm_req,
  output logic [7:0] xm_rdata_r
);

  // elaboration check on the bus width
  if (ADDR_W < 8) begin : g_chk
    $error("ADDR_W must be at least 8");
  end

  logic [7:0] iram [256]; // internal scratch-pad ram
  logic [7:0] aux [256]; // auxiliary ram
  logic [7:0] cfg_r; // boot_flash_size_config
  logic [7:0] sp_r; // stack pointer
  stk_state_t st_r; // stack sequencer
  logic [7:0] call_hi_r; // high return byte waiting
  logic aw_got_r, w_got_r; // write halves already taken
  logic [7:0] awaddr_r; // held write address
  logic [31:0] wdata_r; // held write data
  logic [3:0] wstrb_r; // held strobes

  // boot flash size in kilobytes from the size field
  function automatic logic [2:0] boot_kb(input logic [2:0] s);
    case (s)
      BOOT_NONE: boot_kb = 3'h0;
      BOOT_1K: boot_kb = 3'h1;
      BOOT_2K: boot_kb = 3'h2;
      BOOT_3K: boot_kb = 3'h3;
      default: boot_kb = 3'h4; // 0xx
    endcase
  endfunction

  logic [2:0] boot_flash_size_sel; // size field
  logic [14:0] boot_bytes; // boot flash length
  logic [14:0] app_lim; // application length, also boot base
  assign boot_flash_size_sel = cfg_r[2:0];
  assign boot_bytes = 15'(KB * {12'h000, boot_kb(boot_flash_size_sel)});
  assign app_lim = FLASH_TOTAL - boot_bytes;

  // ---------------- register bus ----------------
  logic aw_fire, w_fire, ar_fire, do_wr;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  assign awready = !aw_got_r && !bvalid;
  assign wready = !w_got_r && !bvalid;
  assign arready = !rvalid;
  assign aw_fire = awvalid && awready;
  assign w_fire = wvalid && wready;
  assign ar_fire = arvalid && arready;
  assign do_wr = (aw_got_r || aw_fire) && (w_got_r || w_fire);
  assign wr_addr = aw_got_r ? awaddr_r : awaddr[7:0];
  assign wr_data = w_got_r ? wdata_r : wdata;
  assign wr_strb = w_got_r ? wstrb_r : wstrb;

  // capture of write halves, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (do_wr) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
    end else begin
      if (aw_fire) begin
        aw_got_r <= 1'b1;
        awaddr_r <= awaddr[7:0];
      end
      if (w_fire) begin
        w_got_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
    end
  end

  // write response and config byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      cfg_r <= CFG_RESET;
    end else if (do_wr) begin
      bvalid <= 1'b1;
      if (wr_addr == REG_CFG) begin
        bresp <= RESP_OKAY;
        if (wr_strb[0]) begin
          cfg_r <= wr_data[7:0];
        end
      end else if (wr_addr == REG_STATUS) begin
        bresp <= RESP_OKAY; // read-only, write ignored
      end else begin
        bresp <= RESP_SLVERR; // unmapped
      end
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid <= 1'b1;
      if (araddr[7:0] == REG_CFG) begin
        rdata <= {24'h000000, cfg_r};
        rresp <= RESP_OKAY;
      end else if (araddr[7:0] == REG_STATUS) begin
        rdata <= {18'h00000, boot_kb(boot_flash_size_sel), boot_mode,
                  bank_select_high, bank_select_low, sp_r};
        rresp <= RESP_OKAY;
      end else begin
        rdata <= 32'h0000_0000;
        rresp <= RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // ---------------- program memory ----------------
  // fetch and code-read decode into the physical flash
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_addr_r <= RESET_VECTOR[14:0];
      flash_page_r <= '0;
      flash_in_boot_r <= 1'b0;
      flash_fault_r <= 1'b0;
      flash_code_read_r <= 1'b0;
    end else if (fetch_valid) begin
      flash_code_read_r <= fetch_code_read;
      if (boot_mode) begin
        // pc zero lands on boot flash start
        flash_addr_r <= 15'(app_lim + fetch_pc[14:0]);
        flash_page_r <= 8'((app_lim + fetch_pc[14:0]) >> PAGE_BITS);
        flash_in_boot_r <= 1'b1;
        flash_fault_r <= fetch_pc >= {1'b0, boot_bytes};
      end else begin
        flash_addr_r <= fetch_pc[14:0];
        flash_page_r <= fetch_pc[14:PAGE_BITS];
        flash_in_boot_r <= 1'b0;
        flash_fault_r <= fetch_pc >= {1'b0, app_lim};
      end
    end
  end

  // fixed interrupt vectors
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vector_addr_r <= VEC_BASE;
    end else if (irq_valid) begin
      vector_addr_r <= 16'(VEC_BASE + VEC_STRIDE * {13'h0000, irq_num});
    end
  end

  // flash operation permission by running block
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_allow_r <= 1'b0;
      prog_deny_r <= 1'b0;
    end else if (prog_req.valid) begin
      if (prog_req.op == OP_READ ||
          (prog_req.target == TGT_BOOT && !boot_mode) ||
          ((prog_req.target == TGT_APP || prog_req.target == TGT_CFG) && boot_mode)) begin
        prog_allow_r <= 1'b1;
        prog_deny_r <= 1'b0;
      end else begin
        prog_allow_r <= 1'b0;
        prog_deny_r <= 1'b1;
      end
    end else begin
      prog_allow_r <= 1'b0;
      prog_deny_r <= 1'b0;
    end
  end

  // ---------------- internal data ----------------
  logic dm_hi, dm_sfr;
  logic [7:0] dm_byte; // ram byte hit by the access
  logic [2:0] dm_bit;
  logic [7:0] reg_addr; // working register location
  assign dm_hi = dm_req.addr[7];
  assign dm_sfr = dm_hi && (dm_req.bit_acc || !dm_req.indirect);
  assign dm_byte = dm_req.bit_acc ? {BITRAM_HI, dm_req.addr[6:3]} : dm_req.addr;
  assign dm_bit = dm_req.addr[2:0];
  assign reg_addr = {3'h0, bank_select_high, bank_select_low, reg_idx};

  // stack sequencer
  logic stk_idle, stk_we, do_push, do_pop;
  logic [7:0] stk_wdata;
  assign stk_idle = (st_r == ST_IDLE);
  assign stack_busy = !stk_idle;
  assign do_push = stk_idle && !call_valid && push_valid;
  assign do_pop = stk_idle && !call_valid && !push_valid && pop_valid;
  assign stk_we = call_valid && stk_idle || !stk_idle || do_push;
  assign stk_wdata = !stk_idle ? call_hi_r : (call_valid ? call_addr[7:0] : push_data);
  assign stack_pointer = sp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_IDLE;
      sp_r <= SP_RESET;
      call_hi_r <= 8'h00;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (call_valid) begin
            sp_r <= sp_r + STEP; // low byte first
            call_hi_r <= call_addr[15:8];
            st_r <= ST_CALL_HI;
          end else if (do_push) begin
            sp_r <= sp_r + STEP;
          end else if (do_pop) begin
            sp_r <= sp_r - STEP;
          end else if (sp_load) begin
            sp_r <= sp_load_val;
          end
        end
        ST_CALL_HI: begin
          sp_r <= sp_r + STEP;
          st_r <= ST_IDLE;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // internal ram writes: stack, then data access, then working register
  always_ff @(posedge aclk) begin
    if (stk_we) begin
      iram[sp_r + STEP] <= stk_wdata;
    end else if (dm_req.valid && dm_req.write && !dm_sfr) begin
      if (dm_req.bit_acc) begin
        iram[dm_byte][dm_bit] <= dm_req.bitval;
      end else begin
        iram[dm_byte] <= dm_req.wdata;
      end
    end else if (reg_valid && reg_write) begin
      iram[reg_addr] <= reg_wdata;
    end
  end

  // internal ram reads and special register decode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dm_rdata_r <= 8'h00;
      dm_rvalid_r <= 1'b0;
      sfr_sel_r <= 1'b0;
      sfr_addr_r <= 8'h00;
      sfr_bit_ok_r <= 1'b0;
      reg_rdata_r <= 8'h00;
      pop_data_r <= 8'h00;
    end else begin
      dm_rvalid_r <= dm_req.valid && !dm_req.write && !dm_sfr;
      sfr_sel_r <= dm_req.valid && dm_sfr;
      if (dm_req.valid) begin
        if (dm_sfr) begin
          // bit address above 7fh names the x0h/x8h register
          sfr_addr_r <= dm_req.bit_acc ? {dm_req.addr[7:3], 3'h0} : dm_req.addr;
          sfr_bit_ok_r <= dm_req.bit_acc || dm_req.addr[2:0] == 3'h0;
        end else if (dm_req.bit_acc) begin
          dm_rdata_r <= {7'h00, iram[dm_byte][dm_bit]};
        end else begin
          dm_rdata_r <= iram[dm_byte];
        end
      end
      if (reg_valid) begin
        reg_rdata_r <= iram[reg_addr];
      end
      if (do_pop) begin
        pop_data_r <= iram[sp_r]; // read before decrement
      end
    end
  end

  // ---------------- auxiliary ram ----------------
  logic [7:0] xm_addr;
  assign xm_addr = xm_req.use_data_pointer_pair ? xm_req.data_pointer_pair[7:0] : xm_req.ri;

  always_ff @(posedge aclk) begin
    if (xm_req.valid && xm_req.write) begin
      aux[xm_addr] <= xm_req.wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xm_rdata_r <= 8'h00;
    end else if (xm_req.valid && !xm_req.write) begin
      xm_rdata_r <= aux[xm_addr];
    end
  end

  // ---------------- checks ----------------
  sequence s_call_start;
    st_r == ST_IDLE && call_valid;
  endsequence
  sequence s_call_end;
    st_r == ST_CALL_HI ##1 st_r == ST_IDLE;
  endsequence

  property p_call;
    @(posedge aclk) disable iff (!aresetn)
    s_call_start |=> s_call_end ##0 (sp_r == 8'($past(sp_r, 2) + 8'h02) &&
      iram[sp_r] == $past(call_addr[15:8], 2));
  endproperty
  a_call: assert property (p_call) else $error("call did not push two bytes");

  property p_push;
    @(posedge aclk) disable iff (!aresetn)
    do_push |=> sp_r == 8'($past(sp_r) + 8'h01) && iram[sp_r] == $past(push_data);
  endproperty
  a_push: assert property (p_push) else $error("push order wrong");

  property p_pop;
    @(posedge aclk) disable iff (!aresetn)
    do_pop |=> pop_data_r == $past(iram[sp_r]) && sp_r == 8'($past(sp_r) - 8'h01);
  endproperty
  a_pop: assert property (p_pop) else $error("pop order wrong");

  property p_sp_reset;
    @(posedge aclk) $rose(aresetn) |-> sp_r == 8'h07 && cfg_r == 8'hff;
  endproperty
  a_sp_reset: assert property (p_sp_reset) else $error("bad reset values");

  property p_vector;
    @(posedge aclk) disable iff (!aresetn)
    irq_valid |=> vector_addr_r == 16'(16'h0003 + 16'h0008 * $past(irq_num));
  endproperty
  a_vector: assert property (p_vector) else $error("vector address wrong");

  property p_app_fetch;
    @(posedge aclk) disable iff (!aresetn)
    fetch_valid && !boot_mode |=> flash_addr_r == $past(fetch_pc[14:0]) &&
      flash_fault_r == ($past(fetch_pc) >= {1'b0, $past(app_lim)});
  endproperty
  a_app_fetch: assert property (p_app_fetch) else $error("app fetch decode wrong");

  property p_boot_fetch;
    @(posedge aclk) disable iff (!aresetn)
    fetch_valid && boot_mode && fetch_pc == 16'h0000 |=>
      flash_in_boot_r && flash_addr_r == $past(app_lim) && (flash_fault_r == ($past(boot_bytes) == 15'h0));
  endproperty
  a_boot_fetch: assert property (p_boot_fetch) else $error("boot remap wrong");

  property p_size;
    @(posedge aclk) disable iff (!aresetn)
    cfg_r[2] == 1'b0 |-> boot_bytes == 15'h1000 && app_lim == 15'h3800;
  endproperty
  a_size: assert property (p_size) else $error("4K split wrong");

  property p_direct_hi;
    @(posedge aclk) disable iff (!aresetn)
    dm_req.valid && !dm_req.bit_acc && dm_req.addr[7] |=>
      sfr_sel_r == !$past(dm_req.indirect) && dm_rvalid_r == ($past(dm_req.indirect) && !$past(dm_req.write));
  endproperty
  a_direct_hi: assert property (p_direct_hi) else $error("high address decode wrong");

  property p_xm;
    @(posedge aclk) disable iff (!aresetn)
    xm_req.valid && xm_req.write |=> aux[$past(xm_addr)] == $past(xm_req.wdata);
  endproperty
  a_xm: assert property (p_xm) else $error("auxiliary write lost");

endmodule

//--- rtl/mmap_pkg.sv
// constants, request carriers and state codes for the memory map decoder
package mmap_pkg;
  // program memory
  localparam logic [15:0] RESET_VECTOR = 16'h0000; // first fetch after reset
  localparam logic [15:0] VEC_BASE = 16'h0003; // first interrupt vector
  localparam logic [15:0] VEC_STRIDE = 16'h0008; // spacing of vectors
  localparam int PAGE_BITS = 7; // flash page of 128 bytes
  localparam logic [14:0] FLASH_TOTAL = 15'h4800; // 18K shared by both blocks
  localparam logic [14:0] KB = 15'h0400; // one kilobyte
  localparam logic [2:0] BOOT_NONE = 3'b111; // no boot flash
  localparam logic [2:0] BOOT_1K = 3'b110;
  localparam logic [2:0] BOOT_2K = 3'b101;
  localparam logic [2:0] BOOT_3K = 3'b100;
  localparam logic [7:0] CFG_RESET = 8'hff; // unprogrammed config byte
  // data memory
  localparam logic [7:0] SP_RESET = 8'h07; // stack pointer after reset
  localparam logic [3:0] BITRAM_HI = 4'h2; // bit ram lives at 20h..2fh
  localparam logic [7:0] STEP = 8'h01; // stack step
  // flash targets and operations
  localparam logic [1:0] TGT_APP = 2'h0;
  localparam logic [1:0] TGT_BOOT = 2'h1;
  localparam logic [1:0] TGT_CFG = 2'h2;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_PROG = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h2;
  // register bus
  localparam logic [7:0] REG_CFG = 8'h00; // boot_flash_size_config
  localparam logic [7:0] REG_STATUS = 8'h04; // read-only state
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // internal data access from the core
  typedef struct packed {
    logic valid;
    logic write;
    logic indirect; // 1 = indirect addressing
    logic bit_acc; // 1 = addr is a bit address
    logic [7:0] addr;
    logic [7:0] wdata;
    logic bitval;
  } dm_req_t;

  // external-move access to the auxiliary ram
  typedef struct packed {
    logic valid;
    logic write;
    logic use_data_pointer_pair; // 1 = data pointer pair, 0 = working register
    logic [15:0] data_pointer_pair;
    logic [7:0] ri;
    logic [7:0] wdata;
  } xm_req_t;

  // flash operation request
  typedef struct packed {
    logic valid;
    logic [1:0] target;
    logic [1:0] op;
  } prog_req_t;

  // stack sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CALL_HI = 2'b10
  } stk_state_t;
endpackage

//--- verif/cpu.sv
// processor core model issuing fetches, data, stack and aux ram requests
`timescale 1ns/10ps
module cpu import mmap_pkg::*; (
  input wire logic aclk,
  output logic boot_mode,
  output logic fetch_valid,
  output logic [15:0] fetch_pc,
  output logic fetch_code_read,
  output logic irq_valid,
  output logic [2:0] irq_num,
  output prog_req_t prog_req,
  output dm_req_t dm_req,
  output logic bank_select_high,
  output logic bank_select_low,
  output logic reg_valid,
  output logic reg_write,
  output logic [2:0] reg_idx,
  output logic [7:0] reg_wdata,
  output logic sp_load,
  output logic [7:0] sp_load_val,
  output logic push_valid,
  output logic [7:0] push_data,
  output logic pop_valid,
  output logic call_valid,
  output logic [15:0] call_addr,
  output xm_req_t xm_req
);
  // everything idle at time zero
  initial begin
    {boot_mode, fetch_valid, fetch_pc, fetch_code_read, irq_valid, irq_num} = '0;
    {prog_req, dm_req, bank_select_high, bank_select_low, reg_valid} = '0;
    {reg_write, reg_idx, reg_wdata, sp_load, sp_load_val, push_valid} = '0;
    {push_data, pop_valid, call_valid, call_addr, xm_req} = '0;
  end
  // boot block select and bank select level
  task automatic mode(input logic b, input logic [1:0] k);
    @(posedge aclk);
    {boot_mode, bank_select_high, bank_select_low} <= {b, k};
    @(posedge aclk);
    #1;
  endtask
  // one-cycle requests; payload lines other than fetch_code_read scramble once released
  task automatic fetch(input logic [15:0] pc, input logic cr);
    @(posedge aclk);
    {fetch_valid, fetch_pc, fetch_code_read} <= {1'b1, pc, cr};
    @(posedge aclk);
    {fetch_valid, fetch_pc} <= {1'b0, ~pc};
    #1;
  endtask
  task automatic irq(input logic [2:0] n);
    @(posedge aclk);
    {irq_valid, irq_num} <= {1'b1, n};
    @(posedge aclk);
    {irq_valid, irq_num} <= {1'b0, ~n};
    #1;
  endtask
  task automatic prog(input logic [1:0] t, o);
    @(posedge aclk);
    prog_req <= {1'b1, t, o};
    @(posedge aclk);
    prog_req <= {1'b0, ~t, ~o};
    #1;
  endtask
  // m is write, indirect, bit; bit value rides on d[0]
  task automatic dm(input logic [2:0] m, input logic [7:0] a, d);
    @(posedge aclk);
    dm_req <= {1'b1, m, a, d, d[0]};
    @(posedge aclk);
    dm_req <= {1'b0, ~m, ~a, ~d, ~d[0]};
    #1;
  endtask
  task automatic rg(input logic w, input logic [2:0] i, input logic [7:0] d);
    @(posedge aclk);
    {reg_valid, reg_write, reg_idx, reg_wdata} <= {1'b1, w, i, d};
    @(posedge aclk);
    {reg_valid, reg_write, reg_idx, reg_wdata} <= {1'b0, ~w, ~i, ~d};
    #1;
  endtask
  // k: 0 load, 1 push, 2 pop, 3 call
  task automatic stk(input logic [1:0] k, input logic [15:0] d);
    @(posedge aclk);
    {sp_load_val, push_data, call_addr} <= {d[7:0], d[7:0], d};
    {sp_load, push_valid, pop_valid, call_valid} <= 4'h8 >> k;
    @(posedge aclk);
    {sp_load, push_valid, pop_valid, call_valid} <= 4'h0;
    {sp_load_val, push_data, call_addr} <= ~{d[7:0], d[7:0], d};
    #1;
  endtask
  // m is write, use pointer pair
  task automatic xm(input logic [1:0] m, input logic [15:0] p, input logic [7:0] r, d);
    @(posedge aclk);
    xm_req <= {1'b1, m, p, r, d};
    @(posedge aclk);
    xm_req <= {1'b0, ~m, ~p, ~r, ~d};
    #1;
  endtask
endmodule

//--- verif/tb.sv
// self-checking bench for the memory map decoder
`timescale 1ns/10ps
`define chk(g, e, m) begin \
  checked++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("unexpected at %0t: %s", $time, m); \
  end \
end
module tb;
  import mmap_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  // core side
  logic boot_mode, fetch_valid, fetch_code_read, irq_valid, bank_select_high, bank_select_low;
  logic [15:0] fetch_pc, call_addr;
  logic [2:0] irq_num, reg_idx;
  prog_req_t prog_req;
  dm_req_t dm_req;
  xm_req_t xm_req;
  logic reg_valid, reg_write, sp_load, push_valid, pop_valid, call_valid;
  logic [7:0] reg_wdata, sp_load_val, push_data;
  // decoder outputs
  logic [14:0] flash_addr_r;
  logic [PAGE_BITS:0] flash_page_r;
  logic flash_in_boot_r, flash_fault_r, flash_code_read_r, prog_allow_r, prog_deny_r;
  logic [15:0] vector_addr_r;
  logic [7:0] dm_rdata_r, sfr_addr_r, reg_rdata_r, pop_data_r, stack_pointer, xm_rdata_r;
  logic dm_rvalid_r, sfr_sel_r, sfr_bit_ok_r, stack_busy;
  int checked = 0;
  int n_mismatch = 0;
  mcu_memory_map_decoder i_mcu_memory_map_decoder (.*);
  cpu i_cpu (.*);
  // 100 MHz clock
  always #5 aclk = ~aclk;
  // verdict and stop
  task automatic end_sim;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // bus write; handshakes seen at the falling edge before they happen
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, dn;
    dn = 1'b0;
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    for (int n = 0; n < 50 && !dn; n++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      dn = bvalid;
      if (dn) `chk(bresp, er, "bresp")
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (dn) bready <= 1'b0;
    end
    if (!dn) begin
      n_mismatch++;
      end_sim;
    end
  endtask
  // bus read with expected data and response
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, dn;
    dn = 1'b0;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    for (int n = 0; n < 50 && !dn; n++) begin
      @(negedge aclk);
      ta = arvalid && arready;
      dn = rvalid;
      if (dn) `chk({rresp, rdata}, {er, ed}, "read")
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (dn) rready <= 1'b0;
    end
    if (!dn) begin
      n_mismatch++;
      end_sim;
    end
  endtask
  // main sequence
  initial begin
    int kb;
    int al;
    logic ok;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    i_cpu.fetch(16'h0000, 1'b0);
    `chk({flash_in_boot_r, flash_addr_r}, 16'h0000, "reset fetch")
    `chk(stack_pointer, 8'h07, "reset sp")
    axr(REG_CFG, 32'h0000_00ff, RESP_OKAY);
    $display("test reset done");
    // every size code, both blocks
    for (int s = 0; s < 8; s++) begin
      kb = (s >= 4) ? 7 - s : 4;
      al = 18432 - kb * 1024;
      axw(REG_CFG, 32'(s), RESP_OKAY);
      axr(REG_STATUS, {18'h0, 3'(kb), 3'b000, 8'h07}, RESP_OKAY);
      i_cpu.fetch(16'(al - 1), 1'b1);
      `chk({flash_in_boot_r, flash_fault_r, flash_addr_r}, 17'(al - 1), "app top")
      `chk(flash_page_r, 8'((al - 1) >> 7), "page")
      `chk(flash_code_read_r, 1'b1, "code read")
      i_cpu.fetch(16'(al), 1'b0);
      `chk({flash_fault_r, flash_code_read_r}, 2'b10, "app end")
      i_cpu.mode(1'b1, 2'b00);
      i_cpu.fetch(16'h0000, 1'b0);
      `chk({flash_in_boot_r, flash_addr_r}, {1'b1, 15'(al)}, "boot start")
      `chk(flash_page_r, 8'(al >> 7), "boot page")
      `chk(flash_fault_r, 1'(kb == 0), "boot empty")
      i_cpu.fetch(16'(kb * 1024), 1'b0);
      `chk(flash_fault_r, 1'b1, "boot end")
      i_cpu.mode(1'b0, 2'b00);
    end
    for (int n = 0; n < 8; n++) begin
      i_cpu.irq(3'(n));
      `chk(vector_addr_r, 16'h0003 + 16'(8 * n), "vector")
    end
    for (int b = 0; b < 2; b++) begin
      i_cpu.mode(1'(b), 2'b00);
      for (int t = 0; t < 9; t++) begin
        i_cpu.prog(2'(t / 3), 2'(t % 3));
        ok = (t % 3 == 0) || ((t / 3 == 1) ? (b == 0) : (b == 1));
        `chk({prog_allow_r, prog_deny_r}, {ok, !ok}, "prog gate")
      end
    end
    i_cpu.mode(1'b0, 2'b00);
    $display("test program memory done");
    // direct and indirect spaces
    i_cpu.dm(3'b100, 8'h05, 8'h3c);
    i_cpu.dm(3'b010, 8'h05, 8'h00);
    `chk({dm_rvalid_r, dm_rdata_r}, 9'h13c, "low ram")
    i_cpu.dm(3'b110, 8'h90, 8'ha5);
    i_cpu.dm(3'b000, 8'h90, 8'h00);
    `chk({sfr_sel_r, dm_rvalid_r, sfr_addr_r}, 10'h290, "direct high")
    i_cpu.dm(3'b010, 8'h90, 8'h00);
    `chk({sfr_sel_r, dm_rvalid_r, dm_rdata_r}, 10'h1a5, "upper ram")
    for (int a = 8'h88; a < 8'h90; a++) begin
      i_cpu.dm(3'b000, 8'(a), 8'h00);
      `chk(sfr_bit_ok_r, 1'(a == 8'h88), "byte sfr")
    end
    i_cpu.dm(3'b001, 8'h8b, 8'h00);
    `chk({sfr_sel_r, sfr_bit_ok_r, sfr_addr_r}, 10'h388, "bit sfr")
    i_cpu.dm(3'b100, 8'h21, 8'h00);
    i_cpu.dm(3'b100, 8'h2f, 8'h00);
    i_cpu.dm(3'b101, 8'h0a, 8'h01);
    i_cpu.dm(3'b101, 8'h7f, 8'h01);
    i_cpu.dm(3'b000, 8'h21, 8'h00);
    `chk(dm_rdata_r, 8'h04, "bit 0ah")
    i_cpu.dm(3'b000, 8'h2f, 8'h00);
    `chk(dm_rdata_r, 8'h80, "bit 7fh")
    for (int k = 0; k < 4; k++) begin
      i_cpu.mode(1'b0, 2'(k));
      i_cpu.rg(1'b1, 3'h3, 8'(8'h40 + k));
      i_cpu.dm(3'b000, 8'(8 * k + 3), 8'h00);
      `chk(dm_rdata_r, 8'(8'h40 + k), "bank")
    end
    i_cpu.mode(1'b0, 2'b00);
    i_cpu.rg(1'b0, 3'h3, 8'h00);
    `chk(reg_rdata_r, 8'h40, "reg read")
    $display("test data memory done");
    // stack order and call
    i_cpu.stk(0, 16'h0030);
    i_cpu.stk(1, 16'h0055);
    `chk(stack_pointer, 8'h31, "push sp")
    i_cpu.dm(3'b010, 8'h31, 8'h00);
    `chk(dm_rdata_r, 8'h55, "push data")
    i_cpu.stk(2, 16'h0000);
    `chk({pop_data_r, stack_pointer}, 16'h5530, "pop")
    i_cpu.stk(3, 16'h1234);
    `chk({stack_busy, stack_pointer}, 9'h131, "call first")
    @(posedge aclk);
    #1;
    `chk({stack_busy, stack_pointer}, 9'h032, "call second")
    i_cpu.dm(3'b010, 8'h31, 8'h00);
    `chk(dm_rdata_r, 8'h34, "ret low")
    i_cpu.dm(3'b010, 8'h32, 8'h00);
    `chk(dm_rdata_r, 8'h12, "ret high")
    i_cpu.xm(2'b10, 16'h0000, 8'hff, 8'h00);
    i_cpu.stk(0, 16'h00fe);
    i_cpu.stk(1, 16'h0077);
    i_cpu.dm(3'b010, 8'hff, 8'h00);
    `chk({stack_pointer, dm_rdata_r}, 16'hff77, "high stack")
    i_cpu.xm(2'b00, 16'h0000, 8'hff, 8'h00);
    `chk(xm_rdata_r, 8'h00, "aux untouched")
    // auxiliary ram
    i_cpu.dm(3'b110, 8'h23, 8'h11);
    i_cpu.xm(2'b10, 16'h0000, 8'h23, 8'h5a);
    i_cpu.xm(2'b01, 16'hab23, 8'h00, 8'h00);
    `chk(xm_rdata_r, 8'h5a, "aux via pointer")
    i_cpu.xm(2'b11, 16'h00ff, 8'h00, 8'h5b);
    i_cpu.xm(2'b00, 16'h0000, 8'hff, 8'h00);
    `chk(xm_rdata_r, 8'h5b, "aux top")
    i_cpu.dm(3'b010, 8'h23, 8'h00);
    `chk(dm_rdata_r, 8'h11, "separate ram")
    $display("test stack and aux done");
    // register bus corners
    axw(REG_CFG, 32'h1234_56f8, RESP_OKAY);
    axr(REG_CFG, 32'h0000_00f8, RESP_OKAY);
    axw(REG_STATUS, 32'hffff_ffff, RESP_OKAY);
    axr(REG_STATUS, {18'h0, 3'h4, 3'b000, 8'hff}, RESP_OKAY);
    axr(8'h08, 32'h0, RESP_SLVERR);
    axw(8'h08, 32'h0, RESP_SLVERR);
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    `chk({flash_addr_r, vector_addr_r, stack_pointer}, {15'h0, 16'h0003, 8'h07}, "rerun")
    axr(REG_CFG, 32'h0000_00ff, RESP_OKAY);
    $display("test register bus done");
    end_sim;
  end
endmodule
